// File: dv/csd_board_model.sv
// Board side: strap pull-ups and platform hub reset driver
`timescale 1ns/100ps
`default_nettype none
module csd_board_model (
    // Bench controls
    input  wire logic [19:0] drive_en,
    input  wire logic [19:0] drive_val,
    input  wire logic        hub_reset_n,
    // Device pins
    input  wire logic [19:0] dev_out,
    input  wire logic [19:0] dev_oe_n,
    output wire logic [19:0] strap_level,
    output wire logic        platform_reset_n
);
    wire logic [19:0] dev_drv;
    assign dev_drv = ~dev_oe_n;
    // Undriven strap reads one through its pull-up
    assign strap_level = (dev_drv & dev_out) | (~dev_drv & ((drive_en & drive_val) | ~drive_en));
    // Reset comes from the hub only
    assign platform_reset_n = hub_reset_n;
endmodule
`default_nettype wire

// File: dv/csd_strap_decoder_tb.sv
// Self-checking bench for the strap decoder
`timescale 1ns/100ps
`default_nettype none
module csd_strap_decoder_tb;
    import csd_pkg::*;
    logic                clk;
    logic                reset;
    logic                hub_reset_n;
    logic                hsel;
    logic                hwrite;
    logic [1:0]          htrans;
    logic [2:0]          hsize;
    logic [31:0]         haddr;
    logic [31:0]         hwdata;
    logic [31:0]         hrdata;
    logic [31:0]         rd;
    logic [19:0]         drive_en;
    logic [19:0]         drive_val;
    logic [19:0]         lvl;
    logic [19:0]         strap_out;
    logic [19:0]         strap_oe_n;
    wire logic [19:0]    strap_level;
    wire logic           platform_reset_n;
    csd_settings_type    settings;
    logic                locked;
    logic                hreadyout;
    logic                hresp;
    logic                msr;
    logic [5:0]          exp6;
    int                  fail_count;
    int                  n_compared;

    csd_board_model csd_board_model_i (.drive_en(drive_en), .drive_val(drive_val),
        .hub_reset_n(hub_reset_n), .dev_out(strap_out), .dev_oe_n(strap_oe_n),
        .strap_level(strap_level), .platform_reset_n(platform_reset_n));
    csd_strap_decoder csd_strap_decoder_i (.clk(clk), .reset(reset),
        .platform_reset_n(platform_reset_n), .config_strap_in(strap_level),
        .config_strap_out(strap_out), .config_strap_oe_n(strap_oe_n), .settings(settings),
        .settings_locked(locked), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata));

    function automatic logic [5:0] model(input logic [19:0] s, input logic m);
        model = {~s[2], s[3] ? m : 1'b1, ~s[4], s[6:5], s[5]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h00000, a};
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task automatic lock_in(input logic [19:0] en, input logic [19:0] val);
        @(posedge clk);
        drive_en <= en;
        drive_val <= val;
        hub_reset_n <= 1'b0;
        lvl = (en & val) | ~en;
        repeat (6) @(posedge clk);
        check({31'h0, locked}, 32'h0);
        hub_reset_n <= 1'b1;
        repeat (5) @(posedge clk);
    endtask

    task automatic verify;
        exp6 = model(lvl, msr);
        check({26'h0, settings}, {26'h0, exp6});
        check({31'h0, locked}, 32'h1);
        rdchk(12'h000, {12'h0, lvl});
        rdchk(12'h004, {26'h0, exp6[0], exp6[2:1], exp6[3], exp6[4], exp6[5]});
    endtask

    task automatic tally_and_finish;
        if (fail_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        tally_and_finish;
    end

    initial begin
        fail_count = 0;
        n_compared = 0;
        reset = 1'b1;
        hub_reset_n = 1'b0;
        drive_en = 20'h00000;
        drive_val = 20'h00000;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h00000000;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        msr = 1'b0;
        void'($urandom(3964));
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        lock_in(20'h00000, 20'h00000);
        verify;
        for (int i = 0; i < 12; i++) begin
            lock_in(20'($urandom) | 20'h00060, {20'($urandom) & 20'hFFF9F} | {13'h0, i[1:0], 5'h0});
            msr = 1'($urandom);
            ahb(1'b1, 12'h008, {31'h0, msr});
            rdchk(12'h008, {31'h0, msr});
            verify;
            drive_en <= 20'hFFFFF;
            drive_val <= ~lvl;
            repeat (6) @(posedge clk);
            verify;
        end
        ahb(1'b1, 12'h000, 32'hFFFFFFFF);
        rdchk(12'h000, {12'h0, lvl});
        rdchk(12'h010, 32'h0);
        check({12'h0, strap_oe_n}, 32'h000FFFFF);
        check({12'h0, strap_out}, 32'h00000000);
        rdchk(12'h00C, 32'h00000003);
        tally_and_finish;
    end
endmodule
`default_nettype wire

// File: hw/csd_strap_decoder.sv
// Configuration strap capture, decode and AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "csd_params.svh"
module csd_strap_decoder #(
    parameter int STRAP_W = `CSD_STRAP_W
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset,
    // Platform reset pin from the platform hub, active low
    input  wire logic                      platform_reset_n,
    // Strap pins, two-way; never driven by this block
    input  wire logic [STRAP_W-1:0]        config_strap_in,
    output var  logic [STRAP_W-1:0]        config_strap_out,
    output var  logic [STRAP_W-1:0]        config_strap_oe_n,
    // Decoded settings
    output var  csd_pkg::csd_settings_type settings,
    output var  logic                      settings_locked,
    // AHB-Lite slave
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output var  logic                      hreadyout,
    output var  logic                      hresp,
    output var  logic [31:0]               hrdata
);
    import csd_pkg::*;

    logic [STRAP_W-1:0] strap_sync;
    logic               prst_n_sync;
    logic [STRAP_W-1:0] raw_reg;
    logic [STRAP_W-1:0] raw_next;
    csd_phase_type      phase_reg;
    csd_phase_type      phase_next;
    csd_settings_type   set_next;
    logic               msr_reg;
    logic               wr_pend_reg;
    logic [`CSD_OFF_W-1:0] wr_addr_reg;

    // Pin levels enter through synchronisers; straps idle at one
    csd_sync #(
        .W       (STRAP_W),
        .RST_VAL (STRAP_W'(`CSD_STRAP_ONES))
    ) u_strap_sync (
        .clk   (clk),
        .reset (reset),
        .d     (config_strap_in),
        .q     (strap_sync)
    );

    // Reset pin is only received, never driven
    csd_sync #(
        .W       (1),
        .RST_VAL (1'h0)
    ) u_prst_sync (
        .clk   (clk),
        .reset (reset),
        .d     (platform_reset_n),
        .q     (prst_n_sync)
    );

    // Capture window follows the platform reset
    wire sampling = (prst_n_sync == 1'h0);
    assign phase_next = sampling ? CSD_SAMPLING : CSD_LOCKED;
    assign raw_next   = sampling ? strap_sync : raw_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_reg <= CSD_SAMPLING;
            raw_reg   <= STRAP_W'(`CSD_STRAP_ONES);
        end else begin
            phase_reg <= phase_next;
            raw_reg   <= raw_next;
        end
    end

    // Decode uses only bits 6:2; the rest are reserved
    wire       lane_bit = raw_reg[`CSD_BIT_LANE_REV];
    wire       dbg_bit  = raw_reg[`CSD_BIT_DBG_SRC];
    wire       edp_bit  = raw_reg[`CSD_BIT_EDP_DIS];
    wire [1:0] bif_bits = raw_reg[`CSD_BIT_BIF_HI:`CSD_BIT_BIF_LO];

    csd_bifurc_type bif_dec;
    always_comb begin
        unique case (bif_bits)
            `CSD_BIF_CODE_X8X4: bif_dec = CSD_BIF_X8_2X4;
            `CSD_BIF_CODE_R01:  bif_dec = CSD_BIF_RSVD01;
            `CSD_BIF_CODE_2X8:  bif_dec = CSD_BIF_2X8;
            `CSD_BIF_CODE_R11:  bif_dec = CSD_BIF_RSVD11;
        endcase
    end

    assign set_next.lane_reversed   = ~lane_bit;
    assign set_next.debug_enable    = dbg_bit ? msr_reg : `CSD_DBG_OVERRIDE;
    assign set_next.edp_enable      = ~edp_bit;
    assign set_next.bifurc          = bif_dec;
    assign set_next.bifurc_reserved = (bif_dec == CSD_BIF_RSVD01) ||
                                      (bif_dec == CSD_BIF_RSVD11);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            settings          <= '{1'h0, `CSD_DBG_MSR_RST, 1'h0, CSD_BIF_RSVD11, 1'h1};
            settings_locked   <= 1'h0;
            config_strap_out  <= '0;
            config_strap_oe_n <= '1;
        end else begin
            settings          <= set_next;
            settings_locked   <= (phase_next == CSD_LOCKED);
            config_strap_out  <= '0;
            config_strap_oe_n <= '1;
        end
    end

    // Bus address phase decode
    wire                  addr_ok  = hsel && htrans[1] && hready;
    wire                  rd_take  = addr_ok && !hwrite;
    wire                  wr_take  = addr_ok && hwrite;
    wire [`CSD_OFF_W-1:0] off      = haddr[`CSD_OFF_W-1:0];
    wire                  sel_raw  = (off == `CSD_OFF_RAW);
    wire                  sel_set  = (off == `CSD_OFF_SET);
    wire                  sel_msr  = (off == `CSD_OFF_MSR);
    wire                  sel_stat = (off == `CSD_OFF_STAT);

    wire [31:0] raw_word  = 32'(raw_reg);
    wire [31:0] set_word  = 32'({settings.bifurc_reserved, settings.bifurc,
                                 settings.edp_enable, settings.debug_enable,
                                 settings.lane_reversed});
    wire [31:0] msr_word  = 32'(msr_reg);
    wire [31:0] stat_word = 32'({prst_n_sync, settings_locked});

    // Unmapped offsets read zero
    wire [31:0] rd_mux = sel_raw  ? raw_word  :
                         sel_set  ? set_word  :
                         sel_msr  ? msr_word  :
                         sel_stat ? stat_word : `CSD_WORD_ZERO;
    wire [31:0] rd_next = rd_take ? rd_mux : `CSD_WORD_ZERO;

    wire msr_wr = wr_pend_reg && (wr_addr_reg == `CSD_OFF_MSR);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hrdata      <= `CSD_WORD_ZERO;
            hreadyout   <= 1'h1;
            hresp       <= `CSD_HRESP_OKAY;
            wr_pend_reg <= 1'h0;
            wr_addr_reg <= '0;
            msr_reg     <= `CSD_DBG_MSR_RST;
        end else begin
            hrdata      <= rd_next;
            hreadyout   <= 1'h1;
            hresp       <= `CSD_HRESP_OKAY;
            wr_pend_reg <= wr_take;
            wr_addr_reg <= off;
            if (msr_wr) begin
                msr_reg <= hwdata[0];
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    logic past_valid_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            past_valid_reg <= 1'h0;
        end else begin
            past_valid_reg <= 1'h1;
        end
    end

    chk_default_ones: assert property (
        past_valid_reg && raw_reg == STRAP_W'(`CSD_STRAP_ONES) |=>
            !settings.lane_reversed && !settings.edp_enable &&
            settings.bifurc == CSD_BIF_RSVD11)
        else $error("all-ones straps did not give default settings");

    chk_reserved_ignored: assert property (
        past_valid_reg && $stable(raw_reg[`CSD_BIT_BIF_HI:`CSD_BIT_LANE_REV]) &&
        $stable(msr_reg) |=> $stable(settings))
        else $error("reserved strap bits changed a setting");

    chk_lane_order: assert property (
        past_valid_reg |=> settings.lane_reversed == !$past(lane_bit))
        else $error("lane reversal does not follow strap bit 2");

    chk_debug_source: assert property (
        past_valid_reg |=> settings.debug_enable ==
            ($past(dbg_bit) ? $past(msr_reg) : `CSD_DBG_OVERRIDE))
        else $error("debug enable does not follow its source");

    chk_edp_enable: assert property (
        past_valid_reg |=> settings.edp_enable == !$past(edp_bit))
        else $error("display port enable does not follow strap bit 4");

    chk_bifurc_map: assert property (
        past_valid_reg && bif_bits == `CSD_BIF_CODE_2X8 |=>
            settings.bifurc == CSD_BIF_2X8 && !settings.bifurc_reserved)
        else $error("bifurcation 10 not decoded as two x8");

    chk_bifurc_rsvd: assert property (
        past_valid_reg && bif_bits[0] |=> settings.bifurc_reserved)
        else $error("reserved bifurcation not flagged");

    chk_latch_hold: assert property (
        prst_n_sync && $past(prst_n_sync) |=> $stable(raw_reg))
        else $error("straps changed outside the capture window");

    chk_latch_take: assert property (
        !prst_n_sync |=> raw_reg == $past(strap_sync))
        else $error("straps not captured during platform reset");

    // Capture window, lock flag and released strap pins
    chk_locked_frozen: assert property (
        phase_reg == CSD_LOCKED |->
            $stable(raw_reg))
        else $error("raw straps moved while locked");

    chk_lock_timing: assert property (
        past_valid_reg |->
            settings_locked == $past(prst_n_sync))
        else $error("lock flag does not follow the platform reset");

    chk_unlock_on_reset: assert property (
        $fell(prst_n_sync) |=>
            !settings_locked)
        else $error("lock flag stayed set in platform reset");

    chk_settings_held: assert property (
        settings_locked && $past(settings_locked) && $past(msr_reg, 2) == $past(msr_reg) |->
            $stable(settings))
        else $error("settings changed while locked");

    chk_straps_released: assert property (
        (&config_strap_oe_n) &&
            !(|config_strap_out))
        else $error("strap pin driven by the block");

    // Decoded fields
    chk_bifurc_x8x4: assert property (
        past_valid_reg && bif_bits == `CSD_BIF_CODE_X8X4 |=>
            settings.bifurc == CSD_BIF_X8_2X4 && !settings.bifurc_reserved)
        else $error("bifurcation 00 not decoded as x8 plus two x4");

    chk_bifurc_r01: assert property (
        past_valid_reg && bif_bits == `CSD_BIF_CODE_R01 |=>
            settings.bifurc == CSD_BIF_RSVD01)
        else $error("bifurcation 01 not kept as reserved code");

    chk_bifurc_r11: assert property (
        past_valid_reg && bif_bits == `CSD_BIF_CODE_R11 |=>
            settings.bifurc == CSD_BIF_RSVD11 && settings.bifurc_reserved)
        else $error("bifurcation 11 not flagged reserved");

    chk_bifurc_valid: assert property (
        past_valid_reg && !bif_bits[0] |=>
            !settings.bifurc_reserved)
        else $error("valid bifurcation flagged reserved");

    chk_edp_disabled: assert property (
        past_valid_reg && edp_bit |=>
            !settings.edp_enable)
        else $error("display port enabled with strap bit 4 high");

    // Permission register path
    chk_debug_override: assert property (
        past_valid_reg && !dbg_bit |=>
            settings.debug_enable == `CSD_DBG_OVERRIDE)
        else $error("debug override not applied");

    chk_msr_write: assert property (
        msr_wr |=>
            msr_reg == $past(hwdata[0]))
        else $error("permission bit write lost");

    chk_msr_hold: assert property (
        !msr_wr |=>
            $stable(msr_reg))
        else $error("permission bit changed without a write");

    cov_reversed: cover property (settings_locked && settings.lane_reversed);
    cov_two_x8: cover property (settings_locked && settings.bifurc == CSD_BIF_2X8);
    cov_msr_write: cover property (msr_wr ##1 settings_locked);
    cov_relatch: cover property (settings_locked ##1 !settings_locked);
    cov_rsvd01: cover property (settings_locked && settings.bifurc == CSD_BIF_RSVD01);

endmodule
`default_nettype wire

// File: hw/csd_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none
module csd_sync #(
    parameter int          W        = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // Levels
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_reg <= RST_VAL;
            q        <= RST_VAL;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// File: pkg/csd_params.svh
// Constants for the configuration strap decoder
`ifndef CSD_PARAMS_SVH
`define CSD_PARAMS_SVH

// Strap port width and reset image (undriven straps read one)
`define CSD_STRAP_W        20
`define CSD_STRAP_ONES     20'hFFFFF

// Strap bit positions
`define CSD_BIT_LANE_REV   2
`define CSD_BIT_DBG_SRC    3
`define CSD_BIT_EDP_DIS    4
`define CSD_BIT_BIF_LO     5
`define CSD_BIT_BIF_HI     6

// Bifurcation strap codes
`define CSD_BIF_CODE_X8X4  2'h0
`define CSD_BIF_CODE_R01   2'h1
`define CSD_BIF_CODE_2X8   2'h2
`define CSD_BIF_CODE_R11   2'h3

// Debug permission register address and the value forced by the override
`define CSD_DBG_MSR_ADDR   12'hC80
`define CSD_DBG_MSR_RST    1'h0
`define CSD_DBG_OVERRIDE   1'h1

// Register byte offsets on the bus
`define CSD_OFF_RAW        12'h000
`define CSD_OFF_SET        12'h004
`define CSD_OFF_MSR        12'h008
`define CSD_OFF_STAT       12'h00C
`define CSD_OFF_W          12

// Settings register field positions
`define CSD_SET_LANE_REV   0
`define CSD_SET_DBG_EN     1
`define CSD_SET_EDP_EN     2
`define CSD_SET_BIF_LO     3
`define CSD_SET_BIF_HI     4
`define CSD_SET_BIF_RSVD   5

// Status register field positions
`define CSD_STAT_LOCKED    0
`define CSD_STAT_PRST      1

// Bus constants
`define CSD_HRESP_OKAY     1'h0
`define CSD_WORD_ZERO      32'h00000000

`endif

// File: pkg/csd_pkg.sv
// Types shared by the configuration strap decoder
`default_nettype none
package csd_pkg;

    typedef enum logic [1:0] {
        CSD_BIF_X8_2X4,
        CSD_BIF_RSVD01,
        CSD_BIF_2X8,
        CSD_BIF_RSVD11
    } csd_bifurc_type;

    typedef enum logic {
        CSD_SAMPLING,
        CSD_LOCKED
    } csd_phase_type;

    typedef struct packed {
        logic           lane_reversed;
        logic           debug_enable;
        logic           edp_enable;
        csd_bifurc_type bifurc;
        logic           bifurc_reserved;
    } csd_settings_type;

endpackage
`default_nettype wire
